// *** common/pftrg_pkg.sv ***
package pftrg_pkg;
    // ------------------------------------------------------------
    // register offsets (byte locations on the serial bus)
    // ------------------------------------------------------------
    localparam logic [7:0] PFTRG_OFS_PT_CTRL = 8'h03;
    localparam logic [7:0] PFTRG_OFS_DELTA_LO = 8'h04;
    localparam logic [7:0] PFTRG_OFS_DELTA_HI = 8'h05;
    localparam logic [7:0] PFTRG_OFS_SPREAD = 8'h06;
    localparam logic [7:0] PFTRG_OFS_PIN_RB = 8'h07;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PFTRG_PT_LOST_BIT = 7;
    localparam int PFTRG_PT_FREEZE_BIT = 6;
    localparam int PFTRG_PT_CLEAR_BIT = 5;
    localparam int PFTRG_SP_PIN_LSB = 4;
    localparam int PFTRG_SP_SRC_BIT = 3;
    localparam int PFTRG_SP_DIS_BIT = 2;
    localparam int PFTRG_SP_LVL_LSB = 0;
    localparam int PFTRG_OE_PINS = 7;
    // ------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------
    localparam logic PFTRG_RST_FREEZE = 1'b0;
    localparam logic PFTRG_RST_CLEAR = 1'b0;
    localparam logic PFTRG_RST_SRC = 1'b0;
    localparam logic PFTRG_RST_DIS = 1'b0;
    localparam logic [1:0] PFTRG_SPREAD_OFF = 2'h0;
    localparam logic [1:0] PFTRG_SPREAD_03 = 2'h1;
    localparam logic [1:0] PFTRG_SPREAD_RSVD = 2'h2;
    localparam logic [1:0] PFTRG_SPREAD_05 = 2'h3;
    localparam logic [15:0] PFTRG_DELTA_ZERO = 16'h0000;
    localparam logic [7:0] PFTRG_BYTE_ZERO = 8'h00;
    localparam logic [1:0] PFTRG_SETTLE_LAST = 2'h3;
endpackage

// *** rtl/pftrg_regs.sv ***
`timescale 1ns/1ps
// Overview of operation
// - control bit 7 reads live lost pin
// - freeze bit holds both delta registers
// - clear bit forces delta registers zero
// - delta is signed frequency difference value
// - offset 4 holds delta low byte
// - offset 5 holds sign and bits 14:8
// - spread bits 5:4 read live pin
// - bit 3 selects spread pll reference
// - bit 2 set disables spread modulation
// - spread level bits latch pin at powerup
// - spread governs fixed, selectable when 100MHz
// - readback register shows enable pin levels
// - byte offset access from serial slave
// - rate choice 0 is 100MHz, 1 is 25MHz
module pftrg_regs
    import pftrg_pkg::*;
#(
    parameter int DELTA_W = 16
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // byte access from the serial slave engine
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // pins and measurement
    input wire logic platform_time_lost_n_i,
    input wire logic [1:0] spread_pin_i,
    input wire logic [PFTRG_OE_PINS-1:0] enable_pin_n_i,
    input wire logic selectable_rate_choice_i,
    input wire logic delta_valid_i,
    input wire logic [DELTA_W-1:0] delta_value_i,
    // to the clock synthesis
    output logic spread_source_filter_o,
    output logic spread_fixed_on_o,
    output logic spread_selectable_on_o,
    output logic [1:0] spread_level_o,
    output logic selectable_rate_25m_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // reset level 0 only shows in readback, nothing edge-detects these
    logic [9:0] sync1_ff;
    logic [9:0] sync2_ff;
    logic lost_s;
    logic [1:0] spin_s;
    logic [PFTRG_OE_PINS-1:0] oe_s;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {platform_time_lost_n_i, spread_pin_i, enable_pin_n_i};
            sync2_ff <= sync1_ff;
        end
    end
    assign lost_s = sync2_ff[9];
    assign spin_s = sync2_ff[8:7];
    assign oe_s = sync2_ff[6:0];

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    logic wr_pt;
    logic wr_sp;
    logic freeze_ff;
    logic clear_ff;
    logic src_ff;
    logic dis_ff;
    logic [1:0] lvl_ff;
    logic lvl_loaded_ff;
    logic [1:0] nxt_lvl;
    // one decode for both write strobes; unmapped offsets never match
    function automatic logic ofs_hit(input logic [7:0] addr, input logic [7:0] ofs);
        ofs_hit = (addr == ofs);
    endfunction

    assign wr_pt = reg_wr_i && ofs_hit(reg_addr_i, PFTRG_OFS_PT_CTRL);
    assign wr_sp = reg_wr_i && ofs_hit(reg_addr_i, PFTRG_OFS_SPREAD);
    // clear is a level: delta stays zero until software writes it back to 0

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            freeze_ff <= PFTRG_RST_FREEZE;
            clear_ff <= PFTRG_RST_CLEAR;
        end else if (wr_pt) begin
            freeze_ff <= reg_wdata_i[PFTRG_PT_FREEZE_BIT];
            clear_ff <= reg_wdata_i[PFTRG_PT_CLEAR_BIT];
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            src_ff <= PFTRG_RST_SRC;
            dis_ff <= PFTRG_RST_DIS;
        end else if (wr_sp) begin
            src_ff <= reg_wdata_i[PFTRG_SP_SRC_BIT];
            dis_ff <= reg_wdata_i[PFTRG_SP_DIS_BIT];
        end
    end

    // ------------------------------------------------------------
    // spread level, pin latched once after release
    // ------------------------------------------------------------
    // settle count lets the pin clear both synchroniser stages first
    logic [1:0] settle_ff;
    logic settled;
    assign settled = (settle_ff == PFTRG_SETTLE_LAST);
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            settle_ff <= 2'h0;
        end else if (!settled) begin
            settle_ff <= settle_ff + 2'h1;
        end
    end

    // software write wins over the one-time pin load
    // a write inside the settle window also cancels the pin load
    always_comb begin
        nxt_lvl = lvl_ff;
        if (wr_sp) begin
            nxt_lvl = reg_wdata_i[PFTRG_SP_LVL_LSB +: 2];
        end else if (settled && !lvl_loaded_ff) begin
            nxt_lvl = spin_s;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lvl_ff <= PFTRG_SPREAD_OFF;
            lvl_loaded_ff <= 1'b0;
        end else begin
            lvl_ff <= nxt_lvl;
            if (wr_sp || settled) begin
                lvl_loaded_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // frequency delta capture
    // ------------------------------------------------------------
    // clear wins over a new sample; freeze only blocks refresh
    // freeze drops samples that arrive meanwhile, none are queued
    logic [DELTA_W-1:0] delta_ff;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            delta_ff <= '0;
        end else if (clear_ff) begin
            delta_ff <= '0;
        end else if (delta_valid_i && !freeze_ff) begin
            delta_ff <= delta_value_i;
        end
    end

    // ------------------------------------------------------------
    // spread and rate steering
    // ------------------------------------------------------------
    // reserved level 10 gives no spread rather than an undefined profile
    logic spread_on;
    assign spread_on = !dis_ff && (lvl_ff != PFTRG_SPREAD_OFF) && (lvl_ff != PFTRG_SPREAD_RSVD);
    assign selectable_rate_25m_o = selectable_rate_choice_i;
    assign spread_fixed_on_o = spread_on;
    assign spread_selectable_on_o = spread_on && !selectable_rate_choice_i;
    assign spread_source_filter_o = src_ff;
    assign spread_level_o = lvl_ff;

    // ------------------------------------------------------------
    // read mux, read-only and reserved bits ignore writes
    // ------------------------------------------------------------
    // the sign lands in bit 7 of the upper byte as the word's top bit
    function automatic logic [7:0] delta_byte(input logic [DELTA_W-1:0] v, input logic upper);
        delta_byte = upper ? v[15:8] : v[7:0];
    endfunction

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = PFTRG_BYTE_ZERO;
        case (reg_addr_i)
            PFTRG_OFS_PT_CTRL: begin
                rd_mux[PFTRG_PT_LOST_BIT] = lost_s;
                rd_mux[PFTRG_PT_FREEZE_BIT] = freeze_ff;
                rd_mux[PFTRG_PT_CLEAR_BIT] = clear_ff;
            end
            PFTRG_OFS_DELTA_LO: begin
                rd_mux = delta_byte(delta_ff, 1'b0);
            end
            PFTRG_OFS_DELTA_HI: begin
                rd_mux = delta_byte(delta_ff, 1'b1);
            end
            PFTRG_OFS_SPREAD: begin
                rd_mux[PFTRG_SP_PIN_LSB +: 2] = spin_s;
                rd_mux[PFTRG_SP_SRC_BIT] = src_ff;
                rd_mux[PFTRG_SP_DIS_BIT] = dis_ff;
                rd_mux[PFTRG_SP_LVL_LSB +: 2] = lvl_ff;
            end
            PFTRG_OFS_PIN_RB: begin
                rd_mux[PFTRG_OE_PINS-1:0] = oe_s;
            end
            // unmapped offsets read as zero
            default: begin
                rd_mux = PFTRG_BYTE_ZERO;
            end
        endcase
    end

    // held between reads so the serial engine may shift it out late
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= PFTRG_BYTE_ZERO;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end
    end
endmodule // pftrg_regs

// *** testbench/pftrg_props.sv ***
`timescale 1ns/1ps
module pftrg_props
    import pftrg_pkg::*;
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic platform_time_lost_n_i,
    input wire logic [PFTRG_OE_PINS-1:0] enable_pin_n_i,
    input wire logic selectable_rate_choice_i,
    input wire logic spread_source_filter_o,
    input wire logic spread_fixed_on_o,
    input wire logic spread_selectable_on_o,
    input wire logic [1:0] spread_level_o
);
    // ----
    // port relations
    // ----
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    a_sel_gate: assert property (spread_selectable_on_o == (spread_fixed_on_o && !selectable_rate_choice_i))
        else $error("selectable spread gate wrong");
    a_level_on: assert property (spread_fixed_on_o |-> spread_level_o[0])
        else $error("spread on with off level");
    a_rd_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved");
    a_unmap_zero: assert property (reg_rd_i && (reg_addr_i < 8'h03 || reg_addr_i > 8'h07) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    // pins pass a two-stage sync, so only settled levels are compared
    a_oe_live: assert property ($stable(enable_pin_n_i)[*4] ##0 (reg_rd_i && reg_addr_i == 8'h07)
        |=> reg_rdata_o == {1'b0, $past(enable_pin_n_i)}) else $error("enable readback wrong");
    a_lost_live: assert property ($stable(platform_time_lost_n_i)[*4] ##0 (reg_rd_i && reg_addr_i == 8'h03)
        |=> reg_rdata_o[7] == $past(platform_time_lost_n_i)) else $error("lost readback wrong");
    a_src_wr: assert property (reg_wr_i && reg_addr_i == 8'h06 |=> spread_source_filter_o == $past(reg_wdata_i[3]))
        else $error("source bit not written");
    a_lvl_wr: assert property (reg_wr_i && reg_addr_i == 8'h06 |=> spread_level_o == $past(reg_wdata_i[1:0]))
        else $error("level bits not written");
    c_spread_wr: cover property (reg_wr_i && reg_addr_i == 8'h06);
    c_delta_rd: cover property (reg_rd_i && reg_addr_i == 8'h05);
    c_pin_rd: cover property (reg_rd_i && reg_addr_i == 8'h07);
endmodule // pftrg_props

// *** testbench/pftrg_host.sv ***
`timescale 1ns/1ps
module pftrg_host (
    input wire logic mclk_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o = 8'h00,
    output logic [7:0] wdata_o = 8'h00,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0
);
    // one byte per strobe at a start offset, address scrambled when idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge mclk_i);
        wr_o = 1'b0;
        addr_o = ~a;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge mclk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
    endtask
endmodule // pftrg_host

// *** testbench/test_pftrg_regs.sv ***
`timescale 1ns/1ps
module test_pftrg_regs;
    import pftrg_pkg::*;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic lost_n = 1'b1;
    logic [1:0] sp_pin = 2'h3;
    logic [6:0] oe_n = 7'h5a;
    logic rate = 1'b0;
    logic dv = 1'b0;
    logic [15:0] dval = 16'h0000;
    logic [7:0] addr, wdata, rdata, got;
    logic wr, rd, src, fon, son, r25;
    logic [1:0] lvl;
    int n_fail = 0;
    int cmp_count = 0;
    always #25 mclk_i = ~mclk_i;
    pftrg_regs pftrg_regs_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .platform_time_lost_n_i(lost_n),
        .spread_pin_i(sp_pin), .enable_pin_n_i(oe_n), .selectable_rate_choice_i(rate), .delta_valid_i(dv),
        .delta_value_i(dval), .spread_source_filter_o(src), .spread_fixed_on_o(fon),
        .spread_selectable_on_o(son), .spread_level_o(lvl), .selectable_rate_25m_o(r25));
    pftrg_host pftrg_host_i (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        pftrg_host_i.rd(a, got);
        chk(got, e);
    endtask
    task automatic smp(input logic [15:0] v);
        @(negedge mclk_i);
        dval = v;
        dv = 1'b1;
        @(negedge mclk_i);
        dv = 1'b0;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge mclk_i);
        arst_n_i = 1'b1;
        repeat (8) @(negedge mclk_i);
        rchk(8'h03, 8'h80);
        rchk(8'h06, 8'h33);
        $display("test reset done");
        smp(16'h8a35);
        pftrg_host_i.wr(8'h03, 8'h40);
        smp(16'h1234);
        rchk(8'h04, 8'h35);
        rchk(8'h05, 8'h8a);
        pftrg_host_i.wr(8'h03, 8'h00);
        smp(16'h7fc1);
        rchk(8'h04, 8'hc1);
        rchk(8'h05, 8'h7f);
        pftrg_host_i.wr(8'h03, 8'h20);
        smp(16'h5555);
        rchk(8'h04, 8'h00);
        rchk(8'h05, 8'h00);
        pftrg_host_i.wr(8'h03, 8'h00);
        $display("test delta done");
        lost_n = 1'b0;
        pftrg_host_i.wr(8'h07, 8'hff);
        pftrg_host_i.wr(8'h03, 8'h9f);
        rchk(8'h07, 8'h5a);
        rchk(8'h03, 8'h00);
        pftrg_host_i.wr(8'h08, 8'hff);
        rchk(8'h08, 8'h00);
        rchk(8'h02, 8'h00);
        $display("test readonly done");
        for (int i = 0; i < 4; i++) begin
            sp_pin = i[1:0];
            rate = i[1];
            pftrg_host_i.wr(8'h06, {2'b11, ~i[1:0], 2'b00, i[1:0]});
            rchk(8'h06, {2'b00, i[1:0], 2'b00, i[1:0]});
            chk({6'h00, fon, son}, {6'h00, i[0], i[0] & ~i[1]});
            chk({7'h00, r25}, {7'h00, i[1]});
        end
        pftrg_host_i.wr(8'h06, 8'h0d);
        rchk(8'h06, 8'h3d);
        chk({6'h00, src, fon}, 8'h02);
        $display("test spread done");
        smp(16'hfffe);
        rchk(8'h04, 8'hfe);
        rchk(8'h05, 8'hff);
        arst_n_i = 1'b0;
        repeat (16) @(negedge mclk_i);
        arst_n_i = 1'b1;
        repeat (8) @(negedge mclk_i);
        rchk(8'h05, 8'h00);
        rchk(8'h03, 8'h00);
        rchk(8'h06, 8'h33);
        $display("test reset rerun done");
        conclude();
    end
    initial begin
        #1000000;
        n_fail++;
        conclude();
    end
endmodule // test_pftrg_regs
bind pftrg_regs pftrg_props pftrg_props_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .platform_time_lost_n_i(platform_time_lost_n_i), .enable_pin_n_i(enable_pin_n_i),
    .selectable_rate_choice_i(selectable_rate_choice_i), .spread_source_filter_o(spread_source_filter_o),
    .spread_fixed_on_o(spread_fixed_on_o), .spread_selectable_on_o(spread_selectable_on_o),
    .spread_level_o(spread_level_o));
